// >>> drp_io_port.sv
/*
 * Register I/O port of the DMA controller: address capture, port match,
 * register load and read-back onto the shared data bus, enable clear.
 * Assumes load/read strobes are already decoded from the cycle code and
 * that the memory-side engine supplies the count-zero pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module drp_io_port (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       write_clk,
    input  wire logic       load_reg,
    input  wire logic       read_reg,
    input  wire logic       port_group_strap_low,
    input  wire logic       port_group_strap_high,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       count_zero,
    output logic            transfer_enable,
    output logic            transfer_direction,
    output logic            transfer_inhibit,
    output logic      [7:0] reg_addr_lo,
    output logic      [7:0] reg_addr_hi,
    output logic      [7:0] reg_count
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // every pin is asynchronous to core_clk; only second stages are read
    logic       wr_s1_r;
    logic       wr_s2_r;
    logic       load_s1_r;
    logic       load_s2_r;
    logic       read_s1_r;
    logic       read_s2_r;
    logic [1:0] strap_s1_r;
    logic [1:0] strap_s2_r;
    logic       czero_s1_r;
    logic       czero_s2_r;
    logic [7:0] data_s1_r;
    logic [7:0] data_s2_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_s1_r   <= 1'b0;
            wr_s2_r   <= 1'b0;
            load_s1_r <= 1'b0;
            load_s2_r <= 1'b0;
            read_s1_r <= 1'b0;
            read_s2_r <= 1'b0;
        end else begin
            wr_s1_r   <= write_clk;
            wr_s2_r   <= wr_s1_r;
            load_s1_r <= load_reg;
            load_s2_r <= load_s1_r;
            read_s1_r <= read_reg;
            read_s2_r <= read_s1_r;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
            czero_s1_r <= 1'b0;
            czero_s2_r <= 1'b0;
        end else begin
            strap_s1_r <= {port_group_strap_high, port_group_strap_low};
            strap_s2_r <= strap_s1_r;
            czero_s1_r <= count_zero;
            czero_s2_r <= czero_s1_r;
        end
    end

    // bus bits may skew; they are used only on a write edge, long after settling
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_s1_r <= drp_pkg::RESET_REG;
            data_s2_r <= drp_pkg::RESET_REG;
        end else begin
            data_s1_r <= data_in;
            data_s2_r <= data_s1_r;
        end
    end

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    // history resets low like the synchronisers, so reset makes no false edge
    logic wr_prev_r;
    logic czero_prev_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_prev_r    <= 1'b0;
            czero_prev_r <= 1'b0;
        end else begin
            wr_prev_r    <= wr_s2_r;
            czero_prev_r <= czero_s2_r;
        end
    end

    // write clock is used only as an edge enable, never as a clock
    wire wr_edge    = wr_s2_r & ~wr_prev_r;
    wire czero_rise = czero_s2_r & ~czero_prev_r;

    // ------------------------------------------------------------
    // address group from straps
    // ------------------------------------------------------------
    function automatic logic [5:0] group_base(input logic [1:0] sel);
        unique case (sel)
            2'h0: group_base = drp_pkg::GROUP_BASE_0;
            2'h1: group_base = drp_pkg::GROUP_BASE_1;
            2'h2: group_base = drp_pkg::GROUP_BASE_2;
            2'h3: group_base = drp_pkg::GROUP_BASE_3;
        endcase
    endfunction : group_base

    wire       addr_cycle   = ~load_s2_r & ~read_s2_r;
    wire       addr_hit     = (data_s2_r[7:2] == group_base(strap_s2_r));
    wire       match_nxt    = addr_hit & addr_cycle;
    wire [1:0] sel_port_nxt = data_s2_r[1:0];

    // ------------------------------------------------------------
    // match capture, held one write period
    // ------------------------------------------------------------
    logic       match_r;
    logic [1:0] sel_port_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_r    <= 1'b0;
            sel_port_r <= 2'h0;
        end else if (wr_edge) begin
            // a data cycle never matches itself, so no third cycle can act
            match_r    <= match_nxt;
            sel_port_r <= sel_port_nxt;
        end
    end

    // ------------------------------------------------------------
    // count-zero capture
    // ------------------------------------------------------------
    logic czero_pend_r;
    wire  czero_seen = czero_pend_r | czero_rise;

    // the write edge consumes the event; an event on that edge acts at once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            czero_pend_r <= 1'b0;
        end else if (wr_edge) begin
            czero_pend_r <= 1'b0;
        end else if (czero_rise) begin
            czero_pend_r <= 1'b1;
        end
    end

    wire clear_enable = wr_edge & czero_seen;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] regs_r [4];
    wire        do_load = wr_edge & load_s2_r & match_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                regs_r[i] <= drp_pkg::RESET_REG;
            end
        end else begin
            if (do_load) begin
                regs_r[sel_port_r] <= data_s2_r;
            end
            // clear wins over a same-edge control load: the count has run out
            if (clear_enable) begin
                regs_r[drp_pkg::PORT_CONTROL][drp_pkg::CTRL_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read-back drive
    // ------------------------------------------------------------
    // registered byte lags a port change by one cycle, well inside the sync delay
    wire [7:0] read_byte = regs_r[sel_port_r];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= drp_pkg::RESET_REG;
        end else begin
            data_out <= read_byte;
        end
    end

    assign data_oe            = read_s2_r & match_r;

    // ------------------------------------------------------------
    // transfer control and register views
    // ------------------------------------------------------------
    assign transfer_enable    = regs_r[drp_pkg::PORT_CONTROL][drp_pkg::CTRL_ENABLE_BIT];
    assign transfer_direction = regs_r[drp_pkg::PORT_CONTROL][drp_pkg::CTRL_DIR_BIT];
    assign transfer_inhibit   = load_s2_r & match_r;
    assign reg_addr_lo        = regs_r[drp_pkg::PORT_ADDR_LO];
    assign reg_addr_hi        = regs_r[drp_pkg::PORT_ADDR_HI];
    assign reg_count          = regs_r[drp_pkg::PORT_COUNT];
endmodule : drp_io_port

`default_nettype wire

// >>> drp_pkg.sv
/*
 * Shared constants for the register I/O port of the DMA controller.
 * Assumes a single core_clk domain; all pins arrive asynchronous.
 */
`default_nettype none

package drp_pkg;
    // ------------------------------------------------------------
    // port numbering within the group of four
    // ------------------------------------------------------------
    localparam logic [1:0] PORT_ADDR_LO  = 2'h0;
    localparam logic [1:0] PORT_ADDR_HI  = 2'h1;
    localparam logic [1:0] PORT_COUNT    = 2'h2;
    localparam logic [1:0] PORT_CONTROL  = 2'h3;
    localparam int         CTRL_ENABLE_BIT = 7;
    localparam int         CTRL_DIR_BIT    = 6;

    // ------------------------------------------------------------
    // address group base selected by the two straps, upper six bits
    // ------------------------------------------------------------
    localparam logic [5:0] GROUP_BASE_0 = 6'h3C;
    localparam logic [5:0] GROUP_BASE_1 = 6'h3D;
    localparam logic [5:0] GROUP_BASE_2 = 6'h3E;
    localparam logic [5:0] GROUP_BASE_3 = 6'h3F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_REG = 8'h00;
endpackage : drp_pkg

`default_nettype wire

// >>> drp_io_port_assertions.sv
/* checker for the drp_io_port ports; bound to every instance at the foot.
   assumes one core_clk domain and the two-flop strobe sync of the design */
`timescale 1ns/1ps
`default_nettype none
module drp_io_port_chk (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       write_clk,
    input wire logic       load_reg,
    input wire logic       read_reg,
    input wire logic       count_zero,
    input wire logic       data_oe,
    input wire logic       transfer_enable,
    input wire logic       transfer_inhibit,
    input wire logic [7:0] data_out,
    input wire logic [7:0] reg_addr_lo,
    input wire logic [7:0] reg_addr_hi,
    input wire logic [7:0] reg_count
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // strobes pass a two-flop sync; the depths leave slack beyond it
    property p_oe_off; !read_reg [*4] |-> !data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("stray drive");
    property p_oe_on; $rose(data_oe) |-> $past(read_reg, 2) || $past(read_reg, 3); endproperty
    a_oe_on: assert property (p_oe_on) else $error("drive without read");
    property p_inh_off; !load_reg [*4] |-> !transfer_inhibit; endproperty
    a_inh_off: assert property (p_inh_off) else $error("stray inhibit");
    property p_inh_on; $rose(transfer_inhibit) |-> $past(load_reg, 2) || $past(load_reg, 3); endproperty
    a_inh_on: assert property (p_inh_on) else $error("inhibit without load");
    property p_hold; !write_clk [*6] |-> $stable({transfer_enable, reg_addr_lo, reg_addr_hi, reg_count}); endproperty
    a_hold: assert property (p_hold) else $error("change off write");
    property p_clear; count_zero [*4] ##1 $rose(write_clk) |-> ##[1:6] !transfer_enable; endproperty
    a_clear: assert property (p_clear) else $error("enable not cleared");
    property p_load; $changed({reg_addr_lo, reg_addr_hi, reg_count}) |-> $past(transfer_inhibit); endproperty
    a_load: assert property (p_load) else $error("load without match");
    property p_dout; data_oe [*2] |-> $stable(data_out); endproperty
    a_dout: assert property (p_dout) else $error("read byte moved");
    c_read: cover property ($rose(data_oe));
    c_load: cover property ($rose(transfer_inhibit));
    c_clear: cover property ($fell(transfer_enable));
endmodule : drp_io_port_chk
bind drp_io_port drp_io_port_chk u_chk (.*);
`default_nettype wire

// >>> drp_cpu_model.sv
/* processor side: one address cycle then one data cycle per I/O access.
   assumes core_clk at 10 ns; data_in is the resolved bus level */
`timescale 1ns/1ps
`default_nettype none
module drp_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       data_oe,
    input  wire logic       transfer_inhibit,
    input  wire logic [7:0] data_out,
    output logic            write_clk,
    output logic            load_reg,
    output logic            read_reg,
    output logic      [7:0] data_in
);
    logic [7:0] bus_v = 8'h00, q_bus;
    logic       drv = 1'b0, q_oe, q_inh;
    // released bus shows the inverse so a stale byte never passes
    assign data_in = data_oe ? data_out : (drv ? bus_v : ~bus_v);
    initial {write_clk, load_reg, read_reg} = 3'h0;
    task cyc(input logic [7:0] v, input logic ld, input logic rd);
        @(negedge core_clk);
        {bus_v, drv, load_reg, read_reg} = {v, !rd, ld, rd};
        repeat (5) @(negedge core_clk);
        {q_bus, q_oe, q_inh} = {data_in, data_oe, transfer_inhibit};
        write_clk = 1'b1;
        repeat (4) @(negedge core_clk);
        {write_clk, load_reg, read_reg, drv} = 4'h0;
        repeat (2) @(negedge core_clk);
    endtask : cyc
    task io(input logic [7:0] a, input logic [7:0] d, input logic rd);
        cyc(a, 1'b0, 1'b0);
        cyc(d, !rd, rd);
    endtask : io
endmodule : drp_cpu_model
`default_nettype wire

// >>> drp_io_port_tb_top.sv
/* self-checking bench for drp_io_port with the processor model.
   assumes the checker is bound from its own file */
`timescale 1ns/1ps
`default_nettype none
module drp_io_port_tb_top;
    logic core_clk = 0, reset_n = 0, port_group_strap_low = 0, port_group_strap_high = 0, count_zero = 0;
    logic write_clk, load_reg, read_reg, data_oe, transfer_enable, transfer_direction, transfer_inhibit;
    logic [7:0] data_in, data_out, reg_addr_lo, reg_addr_hi, reg_count;
    int miscompares = 0, total_checks = 0, cycles = 0;
    drp_io_port uut (.*);
    drp_cpu_model u_cpu (.*);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cycles == 20000) begin
        miscompares++;
        end_sim();
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    task t_groups;
        for (int g = 0; g < 4; g++) begin
            {port_group_strap_high, port_group_strap_low} = 2'(g);
            u_cpu.io({drp_pkg::GROUP_BASE_0 + 6'(g), drp_pkg::PORT_COUNT}, 8'h11 * 8'(g + 1), 1'b0);
            chk(reg_count, 8'h11 * 8'(g + 1));
            chk({7'h00, u_cpu.q_inh}, 8'h01);
            u_cpu.io({drp_pkg::GROUP_BASE_0 + 6'(g + 1), drp_pkg::PORT_COUNT}, 8'h00, 1'b0);
            chk(reg_count, 8'h11 * 8'(g + 1));
            chk({7'h00, u_cpu.q_inh}, 8'h00);
        end
    endtask : t_groups
    task t_read;
        {port_group_strap_high, port_group_strap_low} = 2'h0;
        u_cpu.io({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_ADDR_LO}, 8'hA5, 1'b0);
        u_cpu.io({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_ADDR_HI}, 8'h5A, 1'b0);
        u_cpu.io({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_ADDR_LO}, 8'h00, 1'b1);
        chk(u_cpu.q_bus, 8'hA5);
        chk(reg_addr_hi, 8'h5A);
        chk(reg_addr_lo, 8'hA5);
        chk({7'h00, u_cpu.q_inh}, 8'h00);
        u_cpu.io(8'h00, 8'h00, 1'b1);
        chk({7'h00, u_cpu.q_oe}, 8'h00);
    endtask : t_read
    task t_ctrl;
        u_cpu.io({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_CONTROL}, 8'hC0, 1'b0);
        chk({6'h00, transfer_enable, transfer_direction}, 8'h03);
        count_zero = 1'b1;
        u_cpu.cyc(8'h00, 1'b0, 1'b0);
        count_zero = 1'b0;
        chk({6'h00, transfer_enable, transfer_direction}, 8'h01);
        u_cpu.io({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_CONTROL}, 8'hC0, 1'b0);
        u_cpu.cyc(8'h00, 1'b0, 1'b0);
        chk({6'h00, transfer_enable, transfer_direction}, 8'h03);
        u_cpu.cyc({drp_pkg::GROUP_BASE_0, drp_pkg::PORT_CONTROL}, 1'b0, 1'b0);
        count_zero = 1'b1;
        u_cpu.cyc(8'h80, 1'b1, 1'b0);
        count_zero = 1'b0;
        chk({6'h00, transfer_enable, transfer_direction}, 8'h00);
    endtask : t_ctrl
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        t_groups();
        t_read();
        t_ctrl();
        end_sim();
    end
endmodule : drp_io_port_tb_top
`default_nettype wire
